// ---- src/gppc_pin.sv ----
// One general-purpose pin: input synchroniser, level-change detector, output drive.
// Assumes pin_in comes straight from the pad, asynchronous to clk.
`timescale 1ns/1ps
module gppc_pin
  import gppc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pad side
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  // Control
  input wire logic flip,
  input wire logic drive_en,
  input wire logic drive_lvl,
  // Status
  output logic level,
  output logic change
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  // Two-stage synchroniser; first stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level;
    end
  end

  // Logical level seen by software, after polarity flip
  assign level = sync2_r ^ flip;
  // One-cycle pulse per change of level, whether from the synchronised input or from flip
  assign change = sync2_r ^ prev_r ^ flip;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out <= drive_lvl ^ flip;
      pin_oe_n <= ~drive_en;
    end
  end

endmodule // gppc_pin

// ---- src/gppc_pkg.sv ----
// Package for the general-purpose pin control block: offsets, fields, reset values.
// Assumes a 32-bit APB register bus with byte addresses.
package gppc_pkg;

  localparam int GPPC_ADDR_W = 12;

  // Register byte offsets
  localparam logic [11:0] GPPC_OFS_CTRL = 12'h0FC;
  localparam logic [11:0] GPPC_OFS_EVT_SET = 12'h080;
  localparam logic [11:0] GPPC_OFS_EVT_CLR = 12'h084;
  localparam logic [11:0] GPPC_OFS_MSK_SET = 12'h088;
  localparam logic [11:0] GPPC_OFS_MSK_CLR = 12'h08C;

  // Control register field positions
  localparam int GPPC_BIT_EVT_EN3 = 31;
  localparam int GPPC_BIT_FLIP3 = 29;
  localparam int GPPC_BIT_OE3 = 28;
  localparam int GPPC_BIT_LVL3 = 24;
  localparam int GPPC_BIT_EVT_EN2 = 23;
  localparam int GPPC_BIT_FLIP2 = 21;
  localparam int GPPC_BIT_OE2 = 20;
  localparam int GPPC_BIT_LVL2 = 16;

  // Event and mask register field positions
  localparam int GPPC_EVT_PIN2 = 0;
  localparam int GPPC_EVT_PIN3 = 1;
  localparam int GPPC_EVT_W = 2;

  // Reset values
  localparam logic [31:0] GPPC_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] GPPC_EVT_RST = 2'h0;
  localparam logic [1:0] GPPC_MSK_RST = 2'h0;

endpackage

// ---- src/gppc_top.sv ----
// General-purpose pin control: two pins, control register, event and mask registers.
// Assumes an APB master on clk; pads resolve level from pin_*_out and pin_*_oe_n.
//
// Operation
// - With the pin-three event enable set, every level change of pin three sets its event.
// - With the pin-two event enable set, every level change of pin two sets its event.
// - Pin events are kept in the event register and gated by the mask register.
// - Bit 29 inverts the polarity of pin three.
// - Bit 21 inverts the polarity of pin two.
// - Pin three is driven only while bit 28 is set, otherwise it floats.
// - Pin two is driven only while bit 20 is set, otherwise it floats.
// - Reading bit 24 returns the present pin-three input level.
// - Writing bit 24 sets the level driven on pin three when enabled.
// - Reading bit 16 returns the present pin-two input level.
// - Writing bit 16 sets the level driven on pin two when enabled.
// - Reserved control bits ignore writes and read as zero.
// - A one written to a clear address clears that bit, a zero leaves it.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module gppc_top
  import gppc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pin two
  input wire logic general_pin_two_in,
  output logic general_pin_two_out,
  output logic general_pin_two_oe_n,
  // Pin three
  input wire logic general_pin_three_in,
  output logic general_pin_three_out,
  output logic general_pin_three_oe_n,
  // Interrupt
  output logic irq
);

  logic pin_three_event_enable_r;
  logic pin_three_polarity_flip_r;
  logic pin_three_output_enable_r;
  logic pin_three_level_r;
  logic pin_two_event_enable_r;
  logic pin_two_polarity_flip_r;
  logic pin_two_output_enable_r;
  logic pin_two_level_r;
  logic [1:0] evt_r;
  logic [1:0] msk_r;
  logic [1:0] evt_nxt;
  logic [1:0] msk_nxt;
  logic [1:0] hit;
  logic [31:0] rdata_nxt;
  logic lvl_two;
  logic lvl_three;
  logic chg_two;
  logic chg_three;
  logic wr;
  logic rd;
  logic known;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign known = (paddr == GPPC_OFS_CTRL) || (paddr == GPPC_OFS_EVT_SET) ||
                 (paddr == GPPC_OFS_EVT_CLR) || (paddr == GPPC_OFS_MSK_SET) ||
                 (paddr == GPPC_OFS_MSK_CLR);

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;

  gppc_pin u_pin_two (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(general_pin_two_in),
    .pin_out(general_pin_two_out),
    .pin_oe_n(general_pin_two_oe_n),
    .flip(pin_two_polarity_flip_r),
    .drive_en(pin_two_output_enable_r),
    .drive_lvl(pin_two_level_r),
    .level(lvl_two),
    .change(chg_two)
  );

  gppc_pin u_pin_three (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(general_pin_three_in),
    .pin_out(general_pin_three_out),
    .pin_oe_n(general_pin_three_oe_n),
    .flip(pin_three_polarity_flip_r),
    .drive_en(pin_three_output_enable_r),
    .drive_lvl(pin_three_level_r),
    .level(lvl_three),
    .change(chg_three)
  );

  // Control register; only documented fields exist, reserved bits are not stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_three_event_enable_r <= GPPC_CTRL_RST[GPPC_BIT_EVT_EN3];
      pin_three_polarity_flip_r <= GPPC_CTRL_RST[GPPC_BIT_FLIP3];
      pin_three_output_enable_r <= GPPC_CTRL_RST[GPPC_BIT_OE3];
      pin_three_level_r <= GPPC_CTRL_RST[GPPC_BIT_LVL3];
      pin_two_event_enable_r <= GPPC_CTRL_RST[GPPC_BIT_EVT_EN2];
      pin_two_polarity_flip_r <= GPPC_CTRL_RST[GPPC_BIT_FLIP2];
      pin_two_output_enable_r <= GPPC_CTRL_RST[GPPC_BIT_OE2];
      pin_two_level_r <= GPPC_CTRL_RST[GPPC_BIT_LVL2];
    end else if (wr && paddr == GPPC_OFS_CTRL) begin
      pin_three_event_enable_r <= pwdata[GPPC_BIT_EVT_EN3];
      pin_three_polarity_flip_r <= pwdata[GPPC_BIT_FLIP3];
      pin_three_output_enable_r <= pwdata[GPPC_BIT_OE3];
      pin_three_level_r <= pwdata[GPPC_BIT_LVL3];
      pin_two_event_enable_r <= pwdata[GPPC_BIT_EVT_EN2];
      pin_two_polarity_flip_r <= pwdata[GPPC_BIT_FLIP2];
      pin_two_output_enable_r <= pwdata[GPPC_BIT_OE2];
      pin_two_level_r <= pwdata[GPPC_BIT_LVL2];
    end
  end

  // Enabled level changes become events
  always_comb begin
    hit = 2'h0;
    hit[GPPC_EVT_PIN3] = chg_three && pin_three_event_enable_r;
    hit[GPPC_EVT_PIN2] = chg_two && pin_two_event_enable_r;
  end

  // Event set/clear; a new event wins over a clear in the same cycle
  always_comb begin
    evt_nxt = evt_r;
    if (wr && paddr == GPPC_OFS_EVT_SET) begin
      evt_nxt = evt_nxt | pwdata[GPPC_EVT_W-1:0];
    end
    if (wr && paddr == GPPC_OFS_EVT_CLR) begin
      evt_nxt = evt_nxt & ~pwdata[GPPC_EVT_W-1:0];
    end
    evt_nxt = evt_nxt | hit;
  end

  always_comb begin
    msk_nxt = msk_r;
    if (wr && paddr == GPPC_OFS_MSK_SET) begin
      msk_nxt = msk_nxt | pwdata[GPPC_EVT_W-1:0];
    end
    if (wr && paddr == GPPC_OFS_MSK_CLR) begin
      msk_nxt = msk_nxt & ~pwdata[GPPC_EVT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_r <= GPPC_EVT_RST;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msk_r <= GPPC_MSK_RST;
    end else begin
      msk_r <= msk_nxt;
    end
  end

  // Interrupt output is high while an unmasked event is pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_nxt & msk_nxt);
    end
  end

  // Read mux; clear address of the event register returns the masked view
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      GPPC_OFS_CTRL: begin
        rdata_nxt[GPPC_BIT_EVT_EN3] = pin_three_event_enable_r;
        rdata_nxt[GPPC_BIT_FLIP3] = pin_three_polarity_flip_r;
        rdata_nxt[GPPC_BIT_OE3] = pin_three_output_enable_r;
        rdata_nxt[GPPC_BIT_LVL3] = lvl_three;
        rdata_nxt[GPPC_BIT_EVT_EN2] = pin_two_event_enable_r;
        rdata_nxt[GPPC_BIT_FLIP2] = pin_two_polarity_flip_r;
        rdata_nxt[GPPC_BIT_OE2] = pin_two_output_enable_r;
        rdata_nxt[GPPC_BIT_LVL2] = lvl_two;
      end
      GPPC_OFS_EVT_SET: begin
        rdata_nxt[GPPC_EVT_W-1:0] = evt_r;
      end
      GPPC_OFS_EVT_CLR: begin
        rdata_nxt[GPPC_EVT_W-1:0] = evt_r & msk_r;
      end
      GPPC_OFS_MSK_SET, GPPC_OFS_MSK_CLR: begin
        rdata_nxt[GPPC_EVT_W-1:0] = msk_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered in the setup cycle so it is stable during access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

endmodule // gppc_top

// ---- testbench/general_purpose_pin_control_tb_top.sv ----
// Testbench for the pin control block.
// Assumes board models on both pads and the bound checker.
`timescale 1ns/1ps
module general_purpose_pin_control_tb_top;
  import gppc_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic s;
  logic pready, pslverr, irq, o2, e2, o3, e3, pad2, pad3;
  logic ext2 = 0;
  logic ext3 = 0;
  int err_total = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  gppc_top uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .general_pin_two_in(pad2), .general_pin_two_out(o2), .general_pin_two_oe_n(e2),
    .general_pin_three_in(pad3), .general_pin_three_out(o3), .general_pin_three_oe_n(e3),
    .irq(irq));
  gppc_board b2 (.oe_n(e2), .drv(o2), .ext(ext2), .pad(pad2));
  gppc_board b3 (.oe_n(e3), .drv(o3), .ext(ext3), .pad(pad3));
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pins(input logic [4:0] e);
    @(negedge clk);
    ck({27'h0, irq, o3, e3, o2, e2}, {27'h0, e});
    @(posedge clk);
  endtask
  task automatic t_rst();
    apb(0, GPPC_OFS_CTRL, 0);
    ck(q, GPPC_CTRL_RST);
    ck({31'h0, s}, 32'h0);
    apb(0, GPPC_OFS_EVT_SET, 0);
    ck(q, 32'h0);
    apb(0, 12'h010, 0);
    ck(q, 32'h0);
    ck({31'h0, s}, 32'h1);
    pins(5'h05);
  endtask
  task automatic t_drv();
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      d = 32'h5E5E_FFFF | (i[0] ? 32'h0101_0000 : 0) | (i[1] ? 32'h2020_0000 : 0);
      apb(1, GPPC_OFS_CTRL, d);
      pins((i[0] ^ i[1]) ? 5'h0A : 5'h00);
      repeat (3) @(posedge clk);
      apb(0, GPPC_OFS_CTRL, 0);
      ck(q, d & 32'hB1B1_0000);
    end
  endtask
  task automatic t_flt();
    apb(1, GPPC_OFS_CTRL, 32'h0020_0000);
    ext2 <= 1'b1;
    ext3 <= 1'b1;
    pins(5'h07);
    repeat (3) @(posedge clk);
    apb(0, GPPC_OFS_CTRL, 0);
    ck(q, 32'h0120_0000);
    ext2 <= 1'b0;
    ext3 <= 1'b0;
    apb(1, GPPC_OFS_CTRL, 0);
    repeat (4) @(posedge clk);
  endtask
  task automatic t_evt();
    apb(1, GPPC_OFS_MSK_SET, 32'h3);
    apb(1, GPPC_OFS_CTRL, 32'h8080_0000);
    ext3 <= 1'b1;
    repeat (5) @(posedge clk);
    apb(0, GPPC_OFS_EVT_SET, 0);
    ck(q, 32'h2);
    pins(5'h15);
    apb(1, GPPC_OFS_EVT_CLR, 32'h1);
    apb(0, GPPC_OFS_EVT_SET, 0);
    ck(q, 32'h2);
    apb(1, GPPC_OFS_EVT_CLR, 32'h2);
    apb(0, GPPC_OFS_EVT_SET, 0);
    ck(q, 32'h0);
    ext2 <= 1'b1;
    repeat (5) @(posedge clk);
    pins(5'h15);
    apb(1, GPPC_OFS_MSK_CLR, 32'h3);
    apb(0, GPPC_OFS_EVT_CLR, 0);
    ck(q, 32'h0);
    apb(0, GPPC_OFS_EVT_SET, 0);
    ck(q, 32'h1);
    pins(5'h05);
    apb(1, GPPC_OFS_EVT_CLR, 32'h3);
    apb(1, GPPC_OFS_CTRL, 0);
    ext3 <= 1'b0;
    repeat (5) @(posedge clk);
    apb(0, GPPC_OFS_EVT_SET, 0);
    ck(q, 32'h0);
  endtask
  task automatic results();
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_rst();
    t_drv();
    t_flt();
    t_evt();
    results();
  end
endmodule // general_purpose_pin_control_tb_top

// ---- testbench/gppc_board.sv ----
// Board model for one general-purpose pin.
// Assumes the board level only shows while the block floats the pin.
`timescale 1ns/1ps
module gppc_board (
  // Block side
  input wire logic oe_n,
  input wire logic drv,
  // Board side
  input wire logic ext,
  output logic pad
);
  assign pad = oe_n ? ext : drv;
endmodule // gppc_board

// ---- testbench/gppc_chk_chk.sv ----
// Checker for the pin control block.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ps
module gppc_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins and interrupt
  input wire logic general_pin_two_in,
  input wire logic general_pin_two_oe_n,
  input wire logic general_pin_three_in,
  input wire logic general_pin_three_out,
  input wire logic general_pin_three_oe_n,
  input wire logic irq
);
  logic [31:0] ctrl_q;
  logic [1:0] msk_q;
  logic wr;
  logic rd;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite && paddr == 12'h0FC;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      msk_q <= '0;
    end else if (wr && paddr == 12'h0FC) begin
      ctrl_q <= pwdata;
    end else if (wr && paddr == 12'h088) begin
      msk_q <= msk_q | pwdata[1:0];
    end else if (wr && paddr == 12'h08C) begin
      msk_q <= msk_q & ~pwdata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_oe3;
    wr && paddr == 12'h0FC |=> ##1 general_pin_three_oe_n == !$past(pwdata[28], 2);
  endproperty
  a_oe3: assert property (p_oe3) else $error("pin three enable wrong");
  property p_oe2;
    wr && paddr == 12'h0FC |=> ##1 general_pin_two_oe_n == !$past(pwdata[20], 2);
  endproperty
  a_oe2: assert property (p_oe2) else $error("pin two enable wrong");
  property p_out3;
    wr && paddr == 12'h0FC |=> ##1 general_pin_three_oe_n
      || general_pin_three_out == ($past(pwdata[24], 2) ^ $past(pwdata[29], 2));
  endproperty
  a_out3: assert property (p_out3) else $error("pin three level wrong");
  property p_rsv;
    rd |-> (prdata & 32'h4E4E_FFFF) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_rd3;
    rd && $past(general_pin_three_in, 3) == general_pin_three_in
      && $past(general_pin_three_in, 2) == general_pin_three_in
      && $past(ctrl_q[29], 3) == ctrl_q[29]
      |-> prdata[24] == (general_pin_three_in ^ ctrl_q[29]);
  endproperty
  a_rd3: assert property (p_rd3) else $error("pin three read wrong");
  property p_rd2;
    rd && $past(general_pin_two_in, 3) == general_pin_two_in
      && $past(general_pin_two_in, 2) == general_pin_two_in
      && $past(ctrl_q[21], 3) == ctrl_q[21]
      |-> prdata[16] == (general_pin_two_in ^ ctrl_q[21]);
  endproperty
  a_rd2: assert property (p_rd2) else $error("pin two read wrong");
  property p_ev3;
    $changed(general_pin_three_in) && ctrl_q[31] && msk_q[1] |-> ##[2:4] irq;
  endproperty
  a_ev3: assert property (p_ev3) else $error("pin three event lost");
  property p_mclr;
    wr && paddr == 12'h08C && pwdata[1:0] == 2'h3 |-> ##2 !irq;
  endproperty
  a_mclr: assert property (p_mclr) else $error("irq not masked");
endmodule // gppc_chk
bind gppc_top gppc_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .general_pin_two_in(general_pin_two_in), .general_pin_two_oe_n(general_pin_two_oe_n),
  .general_pin_three_in(general_pin_three_in), .general_pin_three_out(general_pin_three_out),
  .general_pin_three_oe_n(general_pin_three_oe_n), .irq(irq));
